// [src/ddcor_top.sv]
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ddcor_map.svh"

module ddcor_top (
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic [11:0]           S_AXI_AWADDR_I,
  input  wire logic                  S_AXI_AWVALID_I,
  output logic                       S_AXI_AWREADY_O,
  input  wire logic [31:0]           S_AXI_WDATA_I,
  input  wire logic [3:0]            S_AXI_WSTRB_I,
  input  wire logic                  S_AXI_WVALID_I,
  output logic                       S_AXI_WREADY_O,
  output logic [1:0]                 S_AXI_BRESP_O,
  output logic                       S_AXI_BVALID_O,
  input  wire logic                  S_AXI_BREADY_I,
  input  wire logic [11:0]           S_AXI_ARADDR_I,
  input  wire logic                  S_AXI_ARVALID_I,
  output logic                       S_AXI_ARREADY_O,
  output logic [31:0]                S_AXI_RDATA_O,
  output logic [1:0]                 S_AXI_RRESP_O,
  output logic                       S_AXI_RVALID_O,
  input  wire logic                  S_AXI_RREADY_I,
  input  wire logic [`DDCOR_SW-1:0]  SAMP_A_I,
  input  wire logic [`DDCOR_SW-1:0]  SAMP_B_I,
  input  wire logic                  SAMP_VLD_I,
  input  wire logic [`DDCOR_DW-1:0]  DATA_I,
  input  wire logic                  DATA_VLD_I,
  input  wire logic [1:0]            PRESET_PINS_FIRST_I,
  input  wire logic [1:0]            PRESET_PINS_SECOND_I,
  output logic [`DDCOR_DW-1:0]       DATA_O,
  output logic                       DATA_VLD_O,
  output logic                       RANGE_FLAG_A_FIRST_O,
  output logic                       RANGE_FLAG_A_SECOND_O,
  output logic                       RANGE_FLAG_B_FIRST_O,
  output logic                       RANGE_FLAG_B_SECOND_O,
  output logic [3:0]                 RANGE_EMB_O,
  output logic [1:0]                 PRESET_ACT_FIRST_O,
  output logic [1:0]                 PRESET_ACT_SECOND_O,
  output logic                       QUARTER_DECIM_ALIAS_SEL_O,
  output logic                       HALF_DECIM_HIGHPASS_SEL_O,
  output logic                       COMPLEX_GAIN_LIFT_O
);

  localparam int DW = `DDCOR_DW;
  localparam int CW = `DDCOR_CW;

  ddcor_pkg::ddcor_state_type st_r;
  ddcor_pkg::ddcor_state_type st_nxt;

  // ****************************************
  // helpers
  // ****************************************
  // upper byte of the saturated sample magnitude
  function automatic logic [7:0] mag_byte(input logic [`DDCOR_SW-1:0] s);
    logic [`DDCOR_SW-1:0] a;
    a = s[`DDCOR_SW-1] ? (~s + 12'h001) : s;
    if (a[`DDCOR_SW-1]) begin
      a = 12'h7FF;
    end
    return a[10:3];
  endfunction

  function automatic logic [DW-1:0] sat_neg(input logic [DW-1:0] d);
    if (d == 16'h8000) begin
      return 16'h7FFF;
    end
    return ~d + 16'h0001;
  endfunction

  function automatic logic [DW-1:0] sat_dbl(input logic [DW-1:0] d);
    if (d[DW-1] != d[DW-2]) begin
      return d[DW-1] ? 16'h8000 : 16'h7FFF;
    end
    return {d[DW-2:0], 1'b0};
  endfunction

  function automatic logic [8:0] rd_reg(
    input ddcor_pkg::ddcor_state_type s,
    input logic [9:0]                 idx
  );
    unique case (idx)
      `DDCOR_IDX_FILT: rd_reg = {1'b1, s.filt};
      `DDCOR_IDX_LIM1: rd_reg = {1'b1, s.lim1};
      `DDCOR_IDX_LIM2: rd_reg = {1'b1, s.lim2};
      `DDCOR_IDX_PCFG: rd_reg = {1'b1, s.pcfg};
      `DDCOR_IDX_MODE: rd_reg = {1'b1, s.mode};
      `DDCOR_IDX_PSEL: rd_reg = {1'b1, s.psel};
      `DDCOR_IDX_CTRL: rd_reg = {1'b1, s.ctrl};
      `DDCOR_IDX_STAT: rd_reg = {1'b1, s.act_b, s.act_a, s.emb};
      default:         rd_reg = 9'h000;
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0]          mag_a;
    logic [7:0]          mag_b;
    logic [3:0]          hit;
    logic [CW-1:0]       len;
    logic [8:0]          rd;
    logic                ddc_en;
    logic                cplx;
    logic                aw_take;
    logic                w_take;
    mag_a   = 8'h00;
    mag_b   = 8'h00;
    hit     = 4'h0;
    len     = '0;
    rd      = 9'h000;
    ddc_en  = st_r.ctrl[`DDCOR_CTRL_EN];
    cplx    = st_r.ctrl[`DDCOR_CTRL_CPLX];
    aw_take = 1'b0;
    w_take  = 1'b0;
    st_nxt  = st_r;

    // preset pins cross in through two flops
    st_nxt.pa_s1 = PRESET_PINS_FIRST_I;
    st_nxt.pa_s2 = st_r.pa_s1;
    st_nxt.pb_s1 = PRESET_PINS_SECOND_I;
    st_nxt.pb_s2 = st_r.pb_s1;

    // active preset, registered one clock after sampling [RULE_22]
    unique case (st_r.mode[1:0])
      `DDCOR_MODE_REG: begin
        st_nxt.act_a = st_r.psel.preset_select_first;  // [RULE_16] [RULE_19]
        st_nxt.act_b = st_r.psel.preset_select_second; // [RULE_19]
      end
      `DDCOR_MODE_PINS: begin
        st_nxt.act_a = st_r.pa_s2;                     // [RULE_17]
        st_nxt.act_b = st_r.pb_s2;                     // [RULE_17]
      end
      `DDCOR_MODE_SHARE: begin
        st_nxt.act_a = st_r.pa_s2;                     // [RULE_18]
        st_nxt.act_b = st_r.pa_s2;                     // [RULE_18]
      end
      default: begin
        // reserved code keeps the last preset [RULE_18]
        st_nxt.act_a = st_r.act_a;
        st_nxt.act_b = st_r.act_b;
      end
    endcase

    // ****************************************
    // overrange detection
    // ****************************************
    if (SAMP_VLD_I) begin
      mag_a = mag_byte(SAMP_A_I);                      // [RULE_21]
      mag_b = mag_byte(SAMP_B_I);                      // [RULE_21]
      hit[0] = mag_a >= st_r.lim1;                     // [RULE_08]
      hit[1] = mag_a >= st_r.lim2;                     // [RULE_09]
      hit[2] = mag_b >= st_r.lim1;                     // [RULE_08]
      hit[3] = mag_b >= st_r.lim2;                     // [RULE_09]
      st_nxt.emb = hit;                                // [RULE_11]
    end

    // stretch length 8 << N; new field value applies from the next crossing, running counts keep theirs
    len = `DDCOR_STR_BASE << st_r.pcfg.range_pulse_stretch; // [RULE_12] [RULE_13] [RULE_14]
    for (int i = 0; i < 4; i++) begin
      if (hit[i]) begin
        st_nxt.cnt[i] = len - 11'h001;                 // [RULE_12] [RULE_23]
      end else if (st_r.cnt[i] != '0) begin
        st_nxt.cnt[i] = st_r.cnt[i] - 11'h001;
      end
      st_nxt.pin[i] = (hit[i] | (st_r.cnt[i] != '0))
                      & st_r.pcfg.range_pins_enable;  // [RULE_10]
    end

    // ****************************************
    // output stage
    // ****************************************
    st_nxt.dvld = DATA_VLD_I;
    if (DATA_VLD_I) begin
      st_nxt.odd  = ~st_r.odd;
      st_nxt.dout = DATA_I;
      if (ddc_en && !cplx && st_r.filt.invert_spectrum && st_r.odd) begin
        st_nxt.dout = sat_neg(DATA_I);                 // [RULE_03] [RULE_04] [RULE_05]
      end else if (ddc_en && cplx && st_r.filt.complex_gain_lift) begin
        st_nxt.dout = sat_dbl(DATA_I);                 // [RULE_06]
      end
    end
    if (!ddc_en) begin
      st_nxt.odd = 1'b0;
    end

    // ****************************************
    // bus write
    // ****************************************
    aw_take = S_AXI_AWVALID_I && !st_r.axi.aw_ok && !st_r.axi.bvalid;
    w_take  = S_AXI_WVALID_I && !st_r.axi.w_ok && !st_r.axi.bvalid;
    if (aw_take) begin
      st_nxt.axi.aw_ok = 1'b1;
      st_nxt.axi.waddr = S_AXI_AWADDR_I[11:2];
    end
    if (w_take) begin
      st_nxt.axi.w_ok  = 1'b1;
      st_nxt.axi.wdata = S_AXI_WDATA_I[7:0];
      st_nxt.axi.wlane = S_AXI_WSTRB_I[0];
    end
    if (st_r.axi.aw_ok && st_r.axi.w_ok) begin
      st_nxt.axi.aw_ok  = 1'b0;
      st_nxt.axi.w_ok   = 1'b0;
      st_nxt.axi.bvalid = 1'b1;
      rd = rd_reg(st_r, st_r.axi.waddr);
      st_nxt.axi.bresp = rd[8] ? `DDCOR_RESP_OKAY : `DDCOR_RESP_SLV;
      if (st_r.axi.wlane) begin
        unique case (st_r.axi.waddr)
          `DDCOR_IDX_FILT: st_nxt.filt = st_r.axi.wdata; // [RULE_01] [RULE_02]
          `DDCOR_IDX_LIM1: st_nxt.lim1 = st_r.axi.wdata;
          `DDCOR_IDX_LIM2: st_nxt.lim2 = st_r.axi.wdata;
          `DDCOR_IDX_PCFG: st_nxt.pcfg = st_r.axi.wdata;
          `DDCOR_IDX_MODE: st_nxt.mode = st_r.axi.wdata;
          `DDCOR_IDX_PSEL: st_nxt.psel = st_r.axi.wdata;
          `DDCOR_IDX_CTRL: st_nxt.ctrl = st_r.axi.wdata;
          default: begin
          end
        endcase
      end
    end
    if (st_r.axi.bvalid && S_AXI_BREADY_I) begin
      st_nxt.axi.bvalid = 1'b0;
    end

    // ****************************************
    // bus read
    // ****************************************
    if (st_r.axi.rvalid && S_AXI_RREADY_I) begin
      st_nxt.axi.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && !st_r.axi.rvalid) begin
      rd = rd_reg(st_r, S_AXI_ARADDR_I[11:2]);
      st_nxt.axi.rvalid = 1'b1;
      st_nxt.axi.rdata  = rd[7:0];
      st_nxt.axi.rresp  = rd[8] ? `DDCOR_RESP_OKAY : `DDCOR_RESP_SLV;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r      <= '0;
      st_r.filt <= `DDCOR_RST_FILT;  // [RULE_20]
      st_r.lim1 <= `DDCOR_RST_LIM1;
      st_r.lim2 <= `DDCOR_RST_LIM2;
      st_r.pcfg <= `DDCOR_RST_PCFG;  // [RULE_12]
      st_r.mode <= `DDCOR_RST_MODE;
      st_r.psel <= `DDCOR_RST_PSEL;
      st_r.ctrl <= `DDCOR_RST_CTRL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY_O = !st_r.axi.aw_ok && !st_r.axi.bvalid;
  assign S_AXI_WREADY_O  = !st_r.axi.w_ok && !st_r.axi.bvalid;
  assign S_AXI_BVALID_O  = st_r.axi.bvalid;
  assign S_AXI_BRESP_O   = st_r.axi.bresp;
  assign S_AXI_ARREADY_O = !st_r.axi.rvalid;
  assign S_AXI_RVALID_O  = st_r.axi.rvalid;
  assign S_AXI_RRESP_O   = st_r.axi.rresp;
  assign S_AXI_RDATA_O   = {24'h000000, st_r.axi.rdata};

  assign DATA_O                = st_r.dout;
  assign DATA_VLD_O            = st_r.dvld;
  assign RANGE_FLAG_A_FIRST_O  = st_r.pin[0];
  assign RANGE_FLAG_A_SECOND_O = st_r.pin[1];
  assign RANGE_FLAG_B_FIRST_O  = st_r.pin[2];
  assign RANGE_FLAG_B_SECOND_O = st_r.pin[3];
  assign RANGE_EMB_O           = st_r.emb;
  // preset index for the per-converter tuning/phase word banks [RULE_15]
  assign PRESET_ACT_FIRST_O    = st_r.act_a;
  assign PRESET_ACT_SECOND_O   = st_r.act_b;

  assign QUARTER_DECIM_ALIAS_SEL_O = st_r.filt.quarter_decim_alias_sel; // [RULE_01]
  assign HALF_DECIM_HIGHPASS_SEL_O = st_r.filt.half_decim_highpass_sel; // [RULE_02]
  assign COMPLEX_GAIN_LIFT_O       = st_r.filt.complex_gain_lift;       // [RULE_06]

endmodule

// [src/ddcor_map.svh]
// Function
// [RULE_01] alias bit picks 80% or 87.5% quarter filter
// [RULE_02] half filter bit: low-pass clear, high-pass set
// [RULE_03] high-pass decimation inverts, inversion corrects it
// [RULE_04] inversion acts only in enabled real mode
// [RULE_05] inversion negates every odd output sample
// [RULE_06] gain lift doubles complex output only
// [RULE_07] host lifts gain only with image filtered
// [RULE_08] first limit reached sets flag bit 0
// [RULE_09] second limit reached sets flag bit 1
// [RULE_10] pin enable low holds four flag pins low
// [RULE_11] pin enable leaves embedded flags alone
// [RULE_12] pins stretched to 8 times 2^N cycles
// [RULE_13] each stretch step doubles monitoring period
// [RULE_14] stretch change may shift monitoring phase
// [RULE_15] each converter uses one of four presets
// [RULE_16] mode 0 takes presets from select register
// [RULE_17] mode 1 takes each preset from own pins
// [RULE_18] mode 2 first pins drive both; 3 reserved
// [RULE_19] select bits 1-0 first, 3-2 second
// [RULE_20] filter config resets to all zeros
// [RULE_21] limits compare upper magnitude byte per sample
// [RULE_22] new preset applies next clock after sampling
// [RULE_23] new crossing restarts the stretch counter
`ifndef DDCOR_MAP_SVH
`define DDCOR_MAP_SVH

// ****************************************
// register indices, byte address = 4 x index
// ****************************************
`define DDCOR_IDX_FILT   10'h210
`define DDCOR_IDX_LIM1   10'h211
`define DDCOR_IDX_LIM2   10'h212
`define DDCOR_IDX_PCFG   10'h213
`define DDCOR_IDX_MODE   10'h214
`define DDCOR_IDX_PSEL   10'h215
`define DDCOR_IDX_CTRL   10'h200
`define DDCOR_IDX_STAT   10'h201

// ****************************************
// reset values
// ****************************************
`define DDCOR_RST_FILT   8'h00
`define DDCOR_RST_LIM1   8'hF2
`define DDCOR_RST_LIM2   8'hAB
`define DDCOR_RST_PCFG   8'h07
`define DDCOR_RST_MODE   8'h00
`define DDCOR_RST_PSEL   8'h00
`define DDCOR_RST_CTRL   8'h00

// ****************************************
// fields, codes and counts
// ****************************************
`define DDCOR_DW         16
`define DDCOR_SW         12
`define DDCOR_CW         11
`define DDCOR_STR_BASE   11'h008
`define DDCOR_MODE_REG   2'h0
`define DDCOR_MODE_PINS  2'h1
`define DDCOR_MODE_SHARE 2'h2
`define DDCOR_CTRL_EN    0
`define DDCOR_CTRL_CPLX  1
`define DDCOR_CTRL_LINK  2
`define DDCOR_RESP_OKAY  2'h0
`define DDCOR_RESP_SLV   2'h2

`endif

// [src/ddcor_pkg.sv]
`include "ddcor_map.svh"

package ddcor_pkg;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       quarter_decim_alias_sel;
    logic       half_decim_highpass_sel;
    logic       invert_spectrum;
    logic       complex_gain_lift;
  } ddcor_filt_type;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       range_pins_enable;
    logic [2:0] range_pulse_stretch;
  } ddcor_pcfg_type;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] preset_select_second;
    logic [1:0] preset_select_first;
  } ddcor_psel_type;

  typedef struct packed {
    logic       aw_ok;
    logic       w_ok;
    logic [9:0] waddr;
    logic [7:0] wdata;
    logic       wlane;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } ddcor_axi_type;

  typedef struct packed {
    ddcor_filt_type                   filt;
    logic [7:0]                       lim1;
    logic [7:0]                       lim2;
    ddcor_pcfg_type                   pcfg;
    logic [7:0]                       mode;
    ddcor_psel_type                   psel;
    logic [7:0]                       ctrl;
    logic [1:0]                       pa_s1;
    logic [1:0]                       pa_s2;
    logic [1:0]                       pb_s1;
    logic [1:0]                       pb_s2;
    logic [1:0]                       act_a;
    logic [1:0]                       act_b;
    logic [3:0]                       emb;
    logic [3:0][`DDCOR_CW-1:0]        cnt;
    logic [3:0]                       pin;
    logic                             odd;
    logic [`DDCOR_DW-1:0]             dout;
    logic                             dvld;
    ddcor_axi_type                    axi;
  } ddcor_state_type;

endpackage

// [sim/ddcor_chk_properties.sv]
`timescale 1ns/100ps
// ********************
// port checker
// ********************
module ddcor_chk (
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        SAMP_VLD_I,
  input wire logic [1:0]  PRESET_PINS_FIRST_I,
  input wire logic [1:0]  PRESET_PINS_SECOND_I,
  input wire logic        RANGE_FLAG_A_FIRST_O,
  input wire logic        RANGE_FLAG_A_SECOND_O,
  input wire logic        RANGE_FLAG_B_SECOND_O,
  input wire logic [3:0]  RANGE_EMB_O,
  input wire logic [1:0]  PRESET_ACT_FIRST_O,
  input wire logic [1:0]  PRESET_ACT_SECOND_O
);
  logic [11:0] run_r;
  logic [3:0]  pins_w;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  assign pins_w = {PRESET_PINS_SECOND_I, PRESET_PINS_FIRST_I};

  // cycles the second flag of side a has been seen high
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) run_r <= 12'h000;
    else run_r <= RANGE_FLAG_A_SECOND_O ? run_r + 12'h001 : 12'h000;
  end

  a_pulse_min_len: assert property (
    $fell(RANGE_FLAG_A_SECOND_O) && !$past(S_AXI_BVALID_O) |-> run_r >= 12'h008)
    else $error("flag pulse shorter than eight cycles");
  a_emb_on_sample: assert property (
    !$past(SAMP_VLD_I) |-> $stable(RANGE_EMB_O))
    else $error("embedded flags moved without a sample");
  a_first_hit_bit: assert property (
    $rose(RANGE_FLAG_A_FIRST_O) && !$past(S_AXI_BVALID_O) |-> RANGE_EMB_O[0])
    else $error("first flag pin rose without first hit");
  a_second_hit_bit: assert property (
    $rose(RANGE_FLAG_A_SECOND_O) && !$past(S_AXI_BVALID_O) |-> RANGE_EMB_O[1])
    else $error("second flag pin rose without second hit");
  a_b_second_hit: assert property (
    $rose(RANGE_FLAG_B_SECOND_O) && !$past(S_AXI_BVALID_O) |-> RANGE_EMB_O[3])
    else $error("b second flag pin rose without hit");
  a_preset_cause: assert property (
    $changed({PRESET_ACT_SECOND_O, PRESET_ACT_FIRST_O}) |->
      $past(S_AXI_BVALID_O) || ($past(pins_w, 3) != $past(pins_w, 4)))
    else $error("active preset changed without cause");
  a_write_answer: assert property (
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
      |=> ##1 S_AXI_BVALID_O)
    else $error("write response late");
  a_read_answer: assert property (
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && S_AXI_RDATA_O[31:8] == 24'h000000)
    else $error("read response late or wide");

  c_flag_pulse: cover property ($fell(RANGE_FLAG_A_SECOND_O));
  c_preset_move: cover property ($changed(PRESET_ACT_FIRST_O));
  c_read_done: cover property (S_AXI_RVALID_O);
endmodule

bind ddcor_top ddcor_chk u_chk (
  .SYS_CLK_I, .RST_N_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I,
  .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O,
  .S_AXI_RDATA_O, .SAMP_VLD_I, .PRESET_PINS_FIRST_I, .PRESET_PINS_SECOND_I,
  .RANGE_FLAG_A_FIRST_O, .RANGE_FLAG_A_SECOND_O, .RANGE_FLAG_B_SECOND_O, .RANGE_EMB_O,
  .PRESET_ACT_FIRST_O, .PRESET_ACT_SECOND_O
);

// [sim/ddcor_far_model.sv]
`timescale 1ns/100ps
// ********************
// far side: watches flag pins, drives preset pins
// ********************
module ddcor_far_model (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [3:0]       flag_i,
  input  wire logic [1:0]       want_first_i,
  input  wire logic [1:0]       want_second_i,
  output logic      [1:0]       pins_first_o,
  output logic      [1:0]       pins_second_o,
  output logic      [3:0][15:0] run_o
);
  logic [3:0][15:0] cnt_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r         <= '0;
      run_o         <= '0;
      pins_first_o  <= 2'h0;
      pins_second_o <= 2'h0;
    end else begin
      pins_first_o  <= want_first_i;
      pins_second_o <= want_second_i;
      // length of the last finished pulse, in edges seen high
      for (int k = 0; k < 4; k++) begin
        if (flag_i[k]) cnt_r[k] <= cnt_r[k] + 16'h0001;
        else if (cnt_r[k] != 16'h0000) begin
          run_o[k] <= cnt_r[k];
          cnt_r[k] <= 16'h0000;
        end
      end
    end
  end
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps
`include "ddcor_map.svh"
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); \
  end \
end

module tb;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  rst;
    logic [7:0]  wv;
    logic [7:0]  rb;
    logic [1:0]  rp;
  } ddcor_row_type;

  logic                  SYS_CLK_I, RST_N_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O;
  logic                  S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I;
  logic                  S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I;
  logic                  SAMP_VLD_I, DATA_VLD_I, DATA_VLD_O, COMPLEX_GAIN_LIFT_O;
  logic                  RANGE_FLAG_A_FIRST_O, RANGE_FLAG_A_SECOND_O, RANGE_FLAG_B_FIRST_O;
  logic                  RANGE_FLAG_B_SECOND_O, QUARTER_DECIM_ALIAS_SEL_O, HALF_DECIM_HIGHPASS_SEL_O;
  logic [11:0]           S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0]           S_AXI_WDATA_I, S_AXI_RDATA_O;
  logic [3:0]            S_AXI_WSTRB_I, RANGE_EMB_O, flg;
  logic [1:0]            S_AXI_BRESP_O, S_AXI_RRESP_O, PRESET_PINS_FIRST_I, PRESET_PINS_SECOND_I;
  logic [1:0]            PRESET_ACT_FIRST_O, PRESET_ACT_SECOND_O, want_a, rs;
  logic [`DDCOR_SW-1:0]  SAMP_A_I, SAMP_B_I;
  logic [`DDCOR_DW-1:0]  DATA_I, DATA_O;
  logic [3:0][15:0]      run;
  logic [7:0]            prow [4];
  logic [9:0][15:0]      drow [3];
  ddcor_row_type         rows [9];
  int                    mismatches, n_tests;

  assign flg = {RANGE_FLAG_B_SECOND_O, RANGE_FLAG_B_FIRST_O, RANGE_FLAG_A_SECOND_O,
                RANGE_FLAG_A_FIRST_O};

  ddcor_top uut (
    .SYS_CLK_I, .RST_N_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I,
    .S_AXI_WSTRB_I, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
    .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
    .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .SAMP_A_I, .SAMP_B_I, .SAMP_VLD_I,
    .DATA_I, .DATA_VLD_I, .PRESET_PINS_FIRST_I, .PRESET_PINS_SECOND_I, .DATA_O, .DATA_VLD_O,
    .RANGE_FLAG_A_FIRST_O, .RANGE_FLAG_A_SECOND_O, .RANGE_FLAG_B_FIRST_O, .RANGE_FLAG_B_SECOND_O,
    .RANGE_EMB_O, .PRESET_ACT_FIRST_O, .PRESET_ACT_SECOND_O, .QUARTER_DECIM_ALIAS_SEL_O,
    .HALF_DECIM_HIGHPASS_SEL_O, .COMPLEX_GAIN_LIFT_O
  );

  ddcor_far_model far (
    .clk_i (SYS_CLK_I), .rst_n_i (RST_N_I), .flag_i (flg), .want_first_i (want_a),
    .want_second_i (2'h3), .pins_first_o (PRESET_PINS_FIRST_I),
    .pins_second_o (PRESET_PINS_SECOND_I), .run_o (run)
  );

  initial begin
    SYS_CLK_I = 1'b0;
    forever #50 SYS_CLK_I = ~SYS_CLK_I;
  end

  initial begin
    #300000;
    mismatches++;
    finish_test();
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge SYS_CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= {24'h000000, d};
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
    do begin
      @(posedge SYS_CLK_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
    end while (!S_AXI_BVALID_O);
    r = S_AXI_BRESP_O;
    S_AXI_BREADY_I <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge SYS_CLK_I);
    S_AXI_ARADDR_I <= a;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h3;
    do begin
      @(posedge SYS_CLK_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
    end while (!S_AXI_RVALID_O);
    `CHK({S_AXI_RRESP_O, S_AXI_RDATA_O[7:0]}, {er, e})
    S_AXI_RREADY_I <= 1'b0;
  endtask

  task automatic hit(input logic [11:0] a, input logic [11:0] b);
    @(posedge SYS_CLK_I);
    {SAMP_A_I, SAMP_B_I, SAMP_VLD_I} <= {a, b, 1'b1};
    @(posedge SYS_CLK_I);
    SAMP_VLD_I <= 1'b0;
    @(negedge SYS_CLK_I);
  endtask

  task automatic stream(input logic [3:0][15:0] din, input logic [3:0][15:0] e);
    for (int i = 0; i <= 4; i++) begin
      @(posedge SYS_CLK_I);
      DATA_I <= din[3 - (i % 4)];
      DATA_VLD_I <= (i < 4);
      @(negedge SYS_CLK_I);
      if (i > 0) `CHK({DATA_VLD_O, DATA_O}, {1'b1, e[4 - i]})
    end
  endtask

  initial begin
    rows = '{'{12'h800, 8'h00, 8'h00, 8'h00, 2'h0}, '{12'h804, 8'h00, 8'hFF, 8'h00, 2'h0},
             '{12'h840, 8'h00, 8'hAD, 8'hAD, 2'h0}, '{12'h844, 8'hF2, 8'h80, 8'h80, 2'h0},
             '{12'h848, 8'hAB, 8'h40, 8'h40, 2'h0}, '{12'h84C, 8'h07, 8'h08, 8'h08, 2'h0},
             '{12'h850, 8'h00, 8'h00, 8'h00, 2'h0}, '{12'h854, 8'h00, 8'h09, 8'h09, 2'h0},
             '{12'h858, 8'h00, 8'h55, 8'h00, 2'h2}};
    // mode in 7:6, first pin request in 5:4, expected first and second preset in 3:0
    prow = '{8'h36, 8'h6B, 8'h95, 8'hC5};
    drow = '{{16'h0001, 16'h0006, 16'h0100, 16'h0200, 16'h8000, 16'h8000,
               16'h0100, 16'hFE00, 16'h8000, 16'h7FFF},
             {16'h0003, 16'h0003, 16'h3000, 16'h5000, 16'hC000, 16'h9000,
               16'h6000, 16'h7FFF, 16'h8000, 16'h8000},
             {16'h0000, 16'h0003, 16'h1234, 16'h8000, 16'h0001, 16'hFFFF,
               16'h1234, 16'h8000, 16'h0001, 16'hFFFF}};
    {RST_N_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I} = '0;
    {S_AXI_RREADY_I, SAMP_VLD_I, DATA_VLD_I, want_a, S_AXI_WSTRB_I} = {5'h00, 4'hF};
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, SAMP_A_I, SAMP_B_I, DATA_I} = '0;
    repeat (6) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    foreach (rows[k]) begin
      rchk(rows[k].a, rows[k].rst, rows[k].rp);
      wr(rows[k].a, rows[k].wv, rs);
      `CHK(rs, rows[k].rp)
      rchk(rows[k].a, rows[k].rb, rows[k].rp);
    end
    @(negedge SYS_CLK_I);
    `CHK({QUARTER_DECIM_ALIAS_SEL_O, HALF_DECIM_HIGHPASS_SEL_O, COMPLEX_GAIN_LIFT_O}, 3'h7)
    `CHK({PRESET_ACT_SECOND_O, PRESET_ACT_FIRST_O}, 4'h9)
    hit(12'h400, 12'hE00);
    `CHK({RANGE_EMB_O, flg}, 8'hBB)
    repeat (12) @(posedge SYS_CLK_I);
    `CHK(run[1], 16'h0008)
    wr(12'h84C, 8'h09, rs);
    hit(12'h400, 12'h000);
    repeat (20) @(posedge SYS_CLK_I);
    `CHK(run[1], 16'h0010)
    hit(12'h400, 12'h000);
    repeat (3) @(posedge SYS_CLK_I);
    hit(12'h400, 12'h000);
    repeat (25) @(posedge SYS_CLK_I);
    `CHK(run[1], 16'h0015)
    wr(12'h84C, 8'h01, rs);
    hit(12'h400, 12'hE00);
    `CHK({RANGE_EMB_O, flg}, 8'hB0)
    wr(12'h84C, 8'h08, rs);
    hit(12'h3F8, 12'hC08);
    `CHK(RANGE_EMB_O, 4'hA)
    foreach (prow[k]) begin
      want_a <= prow[k][5:4];
      wr(12'h850, {6'h00, prow[k][7:6]}, rs);
      repeat (4) @(posedge SYS_CLK_I);
      @(negedge SYS_CLK_I);
      `CHK({PRESET_ACT_FIRST_O, PRESET_ACT_SECOND_O}, prow[k][3:0])
    end
    // gain lift used only where the image is already removed upstream
    foreach (drow[j]) begin
      wr(12'h840, drow[j][8][7:0], rs);
      wr(12'h800, drow[j][9][7:0], rs);
      stream(drow[j][7:4], drow[j][3:0]);
    end
    @(posedge SYS_CLK_I);
    RST_N_I <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    rchk(12'h84C, 8'h07, 2'h0);
    `CHK({HALF_DECIM_HIGHPASS_SEL_O, COMPLEX_GAIN_LIFT_O, PRESET_ACT_FIRST_O}, 4'h0)
    finish_test();
  end
endmodule
